// *** logic/gpio_input_qualifier_analog_mux.sv ***
/*
 Pin input qualifier and analog pin function selector with an APB
 register slave. Pins arrive asynchronously; peripherals and the
 converter front end sit on pclk.
*/
// Behaviour
// - Analog field upper bit 0 gives digital I/O
// - Upper bit 1 routes converter; reset value
// - Fields 5-4, 21-20 also feed comparators
// - Mode 00 synchronizes only; reset default
// - Modes 01, 10 qualify by sampling window
// - Window qualifier follows the synchronizer
// - One period field per 8 inputs
// - Period sets sample interval in clocks
// - Window is 3 or 6 samples
// - Output changes only on unanimous window
// - Mode 11 passes pin unsynchronized
// - Peripheral input selectable from several pins
// - Unselected peripheral input takes default level
`timescale 1ns/1ns
`default_nettype none

module gpio_input_qualifier_analog_mux
    import gpio_qual_pkg::*;
#(
    parameter int num_pins   = 16,
    parameter int num_periph = 4
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire apb_req_t                 apb_req,
    output var  apb_rsp_t                 apb_rsp,
    input  wire logic [num_pins-1:0]      pin_in,
    input  wire logic [analog_fields-1:0] analog_pin_in,
    output var  logic [num_pins-1:0]      pin_qualified,
    output var  logic [analog_fields-1:0] analog_digital_io,
    output var  logic [analog_fields-1:0] converter_route_en,
    output var  logic                     comparator1_input_a,
    output var  logic                     comparator1_input_b,
    output var  logic [num_periph-1:0]    periph_in
);

    localparam int groups = (num_pins + pins_per_group - 1)
                            / pins_per_group;

    typedef struct packed {
        logic [31:0]                   analog_sel;
        logic [31:0]                   qual_lo;
        logic [31:0]                   qual_hi;
        logic [31:0]                   port_ctrl;
        logic [31:0]                   default_lvl;
        logic [31:0]                   route_sel;
        logic [groups*period_bits-1:0] div_cnt;
        logic [groups-1:0]             sample_en;
        apb_rsp_t                      rsp;
        logic [num_pins-1:0]           qual_q;
        logic [analog_fields-1:0]      aio_q;
        logic [analog_fields-1:0]      route_q;
        logic                          cmp_a;
        logic                          cmp_b;
        logic [num_periph-1:0]         periph_q;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic [num_pins-1:0]      q_raw;
    logic [num_pins-1:0]      q_sync;
    logic [analog_fields-1:0] an_meta;
    logic [analog_fields-1:0] an_sync;
    logic [63:0]              qual_all;
    logic [31:0]              rd_data;
    logic                     rd_hit;
    logic                     access;

    // Analog pins used digitally pass two flops like any pin not in mode 11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_meta <= '0;
            an_sync <= '0;
        end else begin
            an_meta <= analog_pin_in;
            an_sync <= an_meta;
        end
    end

    assign qual_all = {st.qual_hi, st.qual_lo};

    genvar g;
    generate
        for (g = 0; g < num_pins; g++) begin : g_pin
            pin_qualifier u_q (
                .pclk      (pclk),
                .presetn   (presetn),
                .pin_raw   (pin_in[g]),
                .sample_en (st.sample_en[g / pins_per_group]),
                .mode      (qual_mode_t'(qual_all[2*g +: 2])),
                .qual_out  (q_raw[g]),
                .sync_out  (q_sync[g])
            );
        end
    endgenerate

    assign access = apb_req.psel && apb_req.penable;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        case (apb_req.paddr)
            off_analog_sel:  rd_data = st.analog_sel;
            off_qual_sel_lo: rd_data = st.qual_lo;
            off_qual_sel_hi: rd_data = st.qual_hi;
            off_port_ctrl:   rd_data = st.port_ctrl;
            off_pin_state:   rd_data = 32'(st.qual_q);
            off_default_lvl: rd_data = st.default_lvl;
            off_route_sel:   rd_data = st.route_sel;
            default:         rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        logic [period_bits-1:0]    prd;
        logic [route_sel_bits-1:0] rsel;
        logic                      src_ok;
        prd    = '0;
        rsel   = '0;
        src_ok = 1'b0;
        next_st = st;

        // Zero-wait slave: answer in the access cycle itself
        next_st.rsp.pready  = 1'b1;
        next_st.rsp.pslverr = 1'b0;
        next_st.rsp.prdata  = 32'h0000_0000;
        if (access) begin
            next_st.rsp.pslverr = !rd_hit;
            if (!apb_req.pwrite) begin
                next_st.rsp.prdata = rd_data;
            end
        end
        if (access && apb_req.pwrite) begin
            case (apb_req.paddr)
                off_analog_sel:  next_st.analog_sel  = apb_req.pwdata;
                off_qual_sel_lo: next_st.qual_lo     = apb_req.pwdata;
                off_qual_sel_hi: next_st.qual_hi     = apb_req.pwdata;
                off_port_ctrl:   next_st.port_ctrl   = apb_req.pwdata;
                off_default_lvl: next_st.default_lvl = apb_req.pwdata;
                off_route_sel:   next_st.route_sel   = apb_req.pwdata;
                default:         next_st.rsp.prdata  = 32'h0000_0000;
            endcase
        end

        // Period 0 samples every clock; otherwise every period+1 clocks
        for (int k = 0; k < groups; k++) begin
            prd = st.port_ctrl[k*period_bits +: period_bits];
            next_st.sample_en[k] = 1'b0;
            if (st.div_cnt[k*period_bits +: period_bits] >= prd) begin
                next_st.div_cnt[k*period_bits +: period_bits] = '0;
                next_st.sample_en[k] = 1'b1;
            end else begin
                next_st.div_cnt[k*period_bits +: period_bits] =
                    st.div_cnt[k*period_bits +: period_bits] + 1'b1;
            end
        end

        next_st.qual_q = q_raw;

        for (int k = 0; k < analog_fields; k++) begin
            next_st.route_q[k] = st.analog_sel[2*k + field_hi_bit];
            next_st.aio_q[k] = st.analog_sel[2*k + field_hi_bit] ?
                               1'b0 : an_sync[k];
        end
        next_st.cmp_a = st.analog_sel[2*cmp_a_field + field_hi_bit];
        next_st.cmp_b = st.analog_sel[2*cmp_b_field + field_hi_bit];

        // Each peripheral picks pin p+4*(sel-1); sel 0 leaves it unrouted
        for (int p = 0; p < num_periph; p++) begin
            rsel = st.route_sel[p*route_sel_bits +: route_sel_bits];
            src_ok = (rsel != '0) &&
                     (p + num_periph * (int'(rsel) - 1) < num_pins);
            if (src_ok) begin
                next_st.periph_q[p] =
                    q_raw[p + num_periph * (int'(rsel) - 1)];
            end else begin
                next_st.periph_q[p] = st.default_lvl[p];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st             <= '0;
            st.analog_sel  <= analog_sel_reset;
            st.qual_lo     <= qual_sel_reset;
            st.qual_hi     <= qual_sel_reset;
            st.port_ctrl   <= port_ctrl_reset;
            st.default_lvl <= default_lvl_reset;
            st.route_sel   <= route_sel_reset;
            st.route_q     <= '1;
            st.cmp_a       <= 1'b1;
            st.cmp_b       <= 1'b1;
            st.rsp.pready  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Ready stays high; data and error come combinationally from the live decode,
    // so reads return this cycle's decode in the access cycle, not the registered copy
    assign apb_rsp.prdata  = access ? rd_data : 32'h0000_0000;
    assign apb_rsp.pready  = st.rsp.pready;
    assign apb_rsp.pslverr = access ? !rd_hit : 1'b0;

    assign pin_qualified       = st.qual_q;
    assign analog_digital_io   = st.aio_q;
    assign converter_route_en  = st.route_q;
    assign comparator1_input_a = st.cmp_a;
    assign comparator1_input_b = st.cmp_b;
    assign periph_in           = st.periph_q;

endmodule : gpio_input_qualifier_analog_mux

`default_nettype wire

// *** logic/gpio_qual_pkg.sv ***
/*
 Package for the pin input qualifier and analog function selector:
 register offsets, field layouts, reset values, mode encodings.
 Assumes a 32-bit APB register bus and one system clock.
*/
package gpio_qual_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0] off_analog_sel  = 8'h00;
    localparam logic [7:0] off_qual_sel_lo = 8'h04;
    localparam logic [7:0] off_qual_sel_hi = 8'h08;
    localparam logic [7:0] off_port_ctrl   = 8'h0c;
    localparam logic [7:0] off_pin_state   = 8'h10;
    localparam logic [7:0] off_default_lvl = 8'h14;
    localparam logic [7:0] off_route_sel   = 8'h18;

    // Every analog field resets to analog routing (upper bit set)
    localparam logic [31:0] analog_sel_reset  = 32'haaaa_aaaa;
    localparam logic [31:0] qual_sel_reset    = 32'h0000_0000;
    localparam logic [31:0] port_ctrl_reset   = 32'h0000_0000;
    localparam logic [31:0] default_lvl_reset = 32'h0000_0000;
    localparam logic [31:0] route_sel_reset   = 32'h0000_0000;

    localparam int analog_fields  = 16;
    localparam int field_hi_bit   = 1;
    localparam int period_bits    = 8;
    localparam int pins_per_group = 8;
    localparam int route_sel_bits = 2;

    // Analog fields that also feed a comparator input
    localparam int cmp_a_field = 2;
    localparam int cmp_b_field = 10;

    localparam logic [2:0] win_short = 3'h3;
    localparam logic [2:0] win_long  = 3'h6;

    typedef enum logic [1:0] {
        qual_sync   = 2'b00,
        qual_win3   = 2'b01,
        qual_win6   = 2'b10,
        qual_async  = 2'b11
    } qual_mode_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage : gpio_qual_pkg

// *** logic/pin_qualifier.sv ***
/*
 One pin's input qualifier: two-stage synchronizer, then a 3- or
 6-sample window clocked by a shared sample enable, or a bypass.
 Assumes sample_en is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_qualifier
    import gpio_qual_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pin_raw,
    input  wire logic       sample_en,
    input  wire qual_mode_t mode,
    output var  logic       qual_out,
    output var  logic       sync_out
);

    typedef struct packed {
        logic       meta;
        logic       sync;
        logic [5:0] hist;
        logic       out;
    } pq_state_t;

    pq_state_t st;
    pq_state_t next_st;
    logic [5:0] mask;

    always_comb begin
        next_st = st;
        mask = (mode == qual_win6) ? 6'h3f : 6'h07;
        next_st.meta = pin_raw;
        next_st.sync = st.meta;
        case (mode)
            qual_sync: begin
                next_st.out = st.sync;
            end
            qual_win3, qual_win6: begin
                if (sample_en) begin
                    next_st.hist = {st.hist[4:0], st.sync};
                    if (({st.hist[4:0], st.sync} & mask) == mask) begin
                        next_st.out = 1'b1;
                    end else if (({st.hist[4:0], st.sync} & mask)
                                 == 6'h00) begin
                        next_st.out = 1'b0;
                    end
                end
            end
            default: begin
                next_st.out = st.out;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Bypass is combinational on purpose: the receiver synchronizes
    assign qual_out = (mode == qual_async) ? pin_raw : st.out;
    assign sync_out = st.sync;

endmodule : pin_qualifier

`default_nettype wire

// *** tb/gpio_input_qualifier_analog_mux_tb.sv ***
/*
 Testbench: APB register accesses and pin stimulus with checks.
 Assumes the design, its package, the checker and pin_source.
*/
`timescale 1ns/1ns
`default_nettype none
module gpio_input_qualifier_analog_mux_tb;
    import gpio_qual_pkg::*;
    logic        pclk, presetn, cmp_a, cmp_b, e;
    apb_req_t    apb_req;
    apb_rsp_t    apb_rsp;
    logic [15:0] pin_in, analog_pin_in, pq, aio, route;
    logic [3:0]  periph_in;
    logic [31:0] r;
    int          bad_count, cmp_count;
    gpio_input_qualifier_analog_mux dut_u (.pclk(pclk),
        .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .pin_in(pin_in), .analog_pin_in(analog_pin_in),
        .pin_qualified(pq), .analog_digital_io(aio),
        .converter_route_en(route), .comparator1_input_a(cmp_a),
        .comparator1_input_b(cmp_b), .periph_in(periph_in));
    pin_source src_u (.pclk(pclk), .pin_in(pin_in),
        .analog_pin_in(analog_pin_in));
    task automatic report_and_stop;
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask
    // Request held until pready is seen high; bounded wait
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        if (n >= 16) begin
            bad_count++;
            report_and_stop;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        apb(a, 1'b0, 32'h0);
        cmp("read data", x, r);
        cmp("read error", {31'h0, xe}, {31'h0, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        report_and_stop;
    end
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(off_analog_sel, analog_sel_reset, 1'b0);
        cmp("route", 16'hffff, route);
        rd(off_qual_sel_lo, qual_sel_reset, 1'b0);
        rd(8'h1c, 32'h0, 1'b1);
        apb(off_analog_sel, 1'b1, 32'h0);
        settle(2);
        cmp("route", 16'h0, route);
        src_u.drive(16'h0000, 16'ha5c3);
        settle(6);
        cmp("aio", 16'ha5c3, aio);
        apb(off_analog_sel, 1'b1, 32'h0020_0020);
        settle(4);
        cmp("comparators", 2'b11, {cmp_b, cmp_a});
        cmp("aio", 16'ha1c3, aio);
        // Sync-only path: two flops, then qualifier and output flop
        src_u.drive(16'h00ff, 16'h0);
        settle(3);
        cmp("sync", 16'h0, pq);
        settle(1);
        cmp("sync", 16'h00ff, pq);
        apb(off_qual_sel_lo, 1'b1, 32'hffff_ffff);
        src_u.drive(16'hff00, 16'h0);
        settle(1);
        cmp("bypass", 16'hff00, pq);
        apb(off_default_lvl, 1'b1, 32'ha);
        apb(off_route_sel, 1'b1, 32'h2);
        src_u.drive(16'h0010, 16'h0);
        settle(4);
        cmp("periph", 4'hb, periph_in);
        apb(off_route_sel, 1'b1, 32'h3);
        settle(4);
        cmp("periph", 4'ha, periph_in);
        // Pins 0-7: 3 samples every 4 clocks; 8-15: 6 every 3
        src_u.drive(16'h0000, 16'h0);
        apb(off_port_ctrl, 1'b1, 32'h0000_0203);
        apb(off_qual_sel_lo, 1'b1, 32'haaaa_5555);
        settle(40);
        src_u.drive(16'hffff, 16'h0);
        src_u.drive(16'h0000, 16'h0);
        settle(40);
        cmp("glitch", 16'h0, pq);
        src_u.drive(16'hffff, 16'h0);
        settle(8);
        cmp("window", 16'h0, pq);
        settle(7);
        cmp("six", 8'h00, pq[15:8]);
        settle(3);
        cmp("three", 8'hff, pq[7:0]);
        settle(6);
        cmp("six", 16'hffff, pq);
        report_and_stop;
    end
endmodule // gpio_input_qualifier_analog_mux_tb
`default_nettype wire

// *** tb/gpio_qual_sva.sv ***
/*
 Port checker for the qualifier and analog selector.
 Assumes one pclk domain; bound to the top module below.
*/
`timescale 1ns/1ns
`default_nettype none
module gpio_qual_sva
    import gpio_qual_pkg::*;
#(
    parameter int num_pins   = 16,
    parameter int num_periph = 4
) (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire apb_req_t                 apb_req,
    input wire apb_rsp_t                 apb_rsp,
    input wire logic [num_pins-1:0]      pin_in,
    input wire logic [analog_fields-1:0] analog_pin_in,
    input wire logic [num_pins-1:0]      pin_qualified,
    input wire logic [analog_fields-1:0] analog_digital_io,
    input wire logic [analog_fields-1:0] converter_route_en,
    input wire logic                     comparator1_input_a,
    input wire logic                     comparator1_input_b,
    input wire logic [num_periph-1:0]    periph_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    function automatic logic [15:0] hi_bits(logic [31:0] d);
        for (int k = 0; k < 16; k++)
            hi_bits[k] = d[2*k+1];
    endfunction
    sequence access_s;
        apb_req.psel && apb_req.penable;
    endsequence
    sequence wr_analog_s;
        access_s ##0 (apb_req.pwrite && apb_req.paddr == off_analog_sel);
    endsequence
    // Field register lands at the access edge, route flops one later
    property route_p;
        wr_analog_s
            |-> ##2 converter_route_en == hi_bits($past(apb_req.pwdata, 2));
    endproperty
    AST_ROUTE_WR: assert property (route_p)
        else $error("route enables do not follow the written fields");
    AST_RESET_ROUTE: assert property ($rose(presetn) |->
        converter_route_en == 16'hffff) else $error("reset routing");
    AST_CMP_A: assert property (comparator1_input_a ==
        converter_route_en[cmp_a_field]) else $error("comparator a");
    AST_CMP_B: assert property (comparator1_input_b ==
        converter_route_en[cmp_b_field]) else $error("comparator b");
    AST_DIG_OFF: assert property ((converter_route_en &
        analog_digital_io) == 16'h0000) else $error("digital on analog");
    AST_READY: assert property (apb_req.psel |-> apb_rsp.pready)
        else $error("pready low");
    AST_IDLE_DATA: assert property (!apb_req.penable |->
        apb_rsp.prdata == 32'h0) else $error("read data outside access");
    AST_BAD_ADDR: assert property ((access_s ##0
        apb_req.paddr > off_route_sel) |-> apb_rsp.pslverr)
        else $error("unmapped access not refused");
endmodule // gpio_qual_sva
bind gpio_input_qualifier_analog_mux gpio_qual_sva #(
    .num_pins(num_pins), .num_periph(num_periph)) sva_u (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pin_in(pin_in), .analog_pin_in(analog_pin_in),
    .pin_qualified(pin_qualified), .analog_digital_io(analog_digital_io),
    .converter_route_en(converter_route_en),
    .comparator1_input_a(comparator1_input_a),
    .comparator1_input_b(comparator1_input_b), .periph_in(periph_in));
`default_nettype wire

// *** tb/pin_source.sv ***
/*
 External pin model: drives the digital and analog-capable pins.
 Assumes pclk from the bench; pins are plain levels with no pull.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_source (
    input  wire logic        pclk,
    output var  logic [15:0] pin_in,
    output var  logic [15:0] analog_pin_in
);
    initial begin
        pin_in = 16'h0000;
        analog_pin_in = 16'h0000;
    end
    // Levels change just after an edge, like a real driver off-chip
    task automatic drive(input logic [15:0] p, input logic [15:0] a);
        @(posedge pclk);
        pin_in        <= p;
        analog_pin_in <= a;
    endtask
endmodule // pin_source
`default_nettype wire
